/* esr_pkg.sv */
// Package: constants for the Ethernet soft reset control block
package esr_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  ESR_SUBSYS_RESET_OFFS  = 8'h00;
    localparam logic [7:0]  ESR_STATUS_OFFS        = 8'h04;
    localparam logic [31:0] ESR_SUBSYS_RESET_RST   = 32'h0000_0000;
    localparam int          ESR_TRIGGER_BIT        = 0;
    localparam int          ESR_STATUS_ACTIVE_BIT  = 0;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          ESR_PULSE_CYCLES       = 64;
    localparam int          ESR_CNT_W              = 7;
    localparam logic [6:0]  ESR_CNT_LAST           = 7'(ESR_PULSE_CYCLES - 1);
    localparam logic [6:0]  ESR_CNT_RST            = 7'h00;
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ESR_IDLE  = 1'b0,
        ESR_PULSE = 1'b1
    } esr_state_t;
endpackage

/* esr_pulse_gen.sv */
// Reset pulse generator: fixed-length active pulse with restart
`timescale 1ns/100ps
`default_nettype none
module esr_pulse_gen
    import esr_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_start,
    output logic      o_active
);
    esr_state_t          state_reg;
    esr_state_t          state_next;
    logic [ESR_CNT_W-1:0] cnt_reg;
    logic [ESR_CNT_W-1:0] cnt_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ESR_IDLE: begin
                if (i_start) begin
                    state_next = ESR_PULSE;
                    cnt_next   = ESR_CNT_RST;
                end
            end
            ESR_PULSE: begin
                if (i_start) begin
                    cnt_next = ESR_CNT_RST;
                end else if (cnt_reg == ESR_CNT_LAST) begin
                    state_next = ESR_IDLE;
                    cnt_next   = ESR_CNT_RST;
                end else begin
                    cnt_next = cnt_reg + 7'h01;
                end
            end
            default: begin
                state_next = ESR_IDLE;
                cnt_next   = ESR_CNT_RST;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ESR_IDLE;
            cnt_reg   <= ESR_CNT_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign o_active = (state_reg == ESR_PULSE);
endmodule
`default_nettype wire

/* esr_top.sv */
// Top: Ethernet soft reset control with classic Wishbone slave
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module esr_top
    import esr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_err,
    output logic             o_mac_core_resetn,
    output logic             o_dma_engine_resetn,
    output logic             o_soft_reset_active
);
    logic        ack_reg;
    logic        ack_next;
    logic        err_reg;
    logic        err_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic        start_reg;
    logic        start_next;
    logic        active;
    logic        req;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic esr_mapped(input logic [7:0] adr);
        return (adr == ESR_SUBSYS_RESET_OFFS) || (adr == ESR_STATUS_OFFS);
    endfunction

    assign req = i_wb_cyc && i_wb_stb && !ack_reg && !err_reg;

    // ------------------------------------------------------------------
    // Bus next values
    // ------------------------------------------------------------------
    always_comb begin
        ack_next   = 1'b0;
        err_next   = 1'b0;
        dat_next   = dat_reg;
        start_next = 1'b0;
        if (req) begin
            if (esr_mapped(i_wb_adr)) begin
                ack_next = 1'b1;
                dat_next = 32'h0000_0000;
                if (!i_wb_we && i_wb_adr == ESR_STATUS_OFFS) begin
                    dat_next[ESR_STATUS_ACTIVE_BIT] = active;
                end
                if (i_wb_we && i_wb_adr == ESR_SUBSYS_RESET_OFFS && i_wb_sel[0]
                    && i_wb_dat[ESR_TRIGGER_BIT]) begin
                    start_next = 1'b1;
                end
            end else begin
                err_next = 1'b1;
                dat_next = 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            dat_reg   <= ESR_SUBSYS_RESET_RST;
            start_reg <= 1'b0;
        end else begin
            ack_reg   <= ack_next;
            err_reg   <= err_next;
            dat_reg   <= dat_next;
            start_reg <= start_next;
        end
    end

    // ------------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------------
    esr_pulse_gen u_pulse (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_start  (start_reg),
        .o_active (active)
    );

    // Only MAC core and DMA engine see the reset
    assign o_mac_core_resetn   = !active;
    assign o_dma_engine_resetn = !active;
    assign o_soft_reset_active = active;
    assign o_wb_ack            = ack_reg;
    assign o_wb_err            = err_reg;
    assign o_wb_dat            = dat_reg;
endmodule
`default_nettype wire

/* esr_top_sva.sv */
// Assertions for esr_top
`timescale 1ns/100ps
`default_nettype none
module esr_top_sva (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_wb_err,
    input wire logic        o_mac_core_resetn,
    input wire logic        o_dma_engine_resetn,
    input wire logic        o_soft_reset_active
);
    logic [7:0] age_reg, age_next;
    always_comb age_next = (i_wb_cyc & i_wb_stb & i_wb_we & !o_wb_ack & i_wb_adr == 8'h00
        & i_wb_sel[0] & i_wb_dat[0]) ? 8'h00 : age_reg + {7'h0, age_reg != 8'hff};
    always_ff @(posedge i_clk or negedge i_resetn)
        if (!i_resetn) age_reg <= 8'hff;
        else age_reg <= age_next;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_len; age_reg != 8'h00 |-> o_soft_reset_active == (age_reg <= 8'h40)
        && o_mac_core_resetn != o_soft_reset_active && o_dma_engine_resetn == o_mac_core_resetn;
        endproperty
    a_len: assert property (p_len) else $error("bad pulse");
    property p_rd; i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == 8'h00
        |=> o_wb_ack && o_wb_dat == 32'h0; endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_rstn;
        o_mac_core_resetn == !o_soft_reset_active && o_dma_engine_resetn == o_mac_core_resetn;
    endproperty
    a_rstn: assert property (p_rstn) else $error("bad reset outputs");
    property p_ack; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack too long");
    property p_err; i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err && i_wb_adr != 8'h00
        && i_wb_adr != 8'h04 |=> o_wb_err && !o_wb_ack; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_stat; i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && !o_wb_err
        && i_wb_adr == 8'h04 |=> o_wb_dat == {31'h0, $past(o_soft_reset_active)}; endproperty
    a_stat: assert property (p_stat) else $error("bad status");
    property p_wr0; !o_soft_reset_active && i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack
        && !o_wb_err && i_wb_adr == 8'h00 && !(i_wb_sel[0] && i_wb_dat[0])
        |=> ##1 !o_soft_reset_active; endproperty
    a_wr0: assert property (p_wr0) else $error("zero write started reset");
    c_trig: cover property (age_reg == 8'h00);
    c_rt: cover property (age_reg == 8'h00 && o_soft_reset_active);
    c_rd: cover property (o_wb_ack);
endmodule
bind esr_top esr_top_sva u_sva (.*);
`default_nettype wire

/* testbench.sv */
// Bench for esr_top
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        i_clk = 1'b0, i_resetn = 1'b0, cyc = 1'b0, we = 1'b0, ack, act;
    logic        err, mrn, drn, got_err = 1'b0;
    logic [3:0]  sel = 4'hf;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, o_wb_dat;
    int          bad_count = 0, checked = 0, n = 0;
    esr_top dut (.i_clk, .i_resetn, .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat, .o_wb_ack(ack),
        .o_wb_err(err), .o_mac_core_resetn(mrn), .o_dma_engine_resetn(drn),
        .o_soft_reset_active(act));
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        bad_count += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {cyc, we, adr, wd} <= {1'b1, w, a, d};
        do @(posedge i_clk); while (!ack && !err);
        got_err = err;
        cyc <= 1'b0;
    endtask
    task count(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge i_clk);
            n += act;
            check({mrn, drn}, {2{!act}});
        end
    endtask
    task t_pulse;
        bus(1'b0, 8'h00, 32'h0);
        check(o_wb_dat, 32'h0);
        bus(1'b1, 8'h00, 32'h1);
        count(70);
        check(n, 64);
        bus(1'b0, 8'h00, 32'h0);
        check(o_wb_dat, 32'h0);
        $display("pulse done");
    endtask
    task t_restart;
        bus(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge i_clk);
        bus(1'b0, 8'h04, 32'h0);
        check(o_wb_dat, 32'h1);
        bus(1'b1, 8'h00, 32'h1);
        count(80);
        check(n, 64);
        bus(1'b0, 8'h04, 32'h0);
        check(o_wb_dat, 32'h0);
        $display("restart done");
    endtask
    task t_ignore;
        bus(1'b1, 8'h00, 32'h0);
        sel <= 4'he;
        bus(1'b1, 8'h00, 32'h1);
        sel <= 4'hf;
        count(70);
        check(n, 0);
        bus(1'b0, 8'h08, 32'h0);
        check(got_err, 1'b1);
        $display("ignore done");
    endtask
    task summarize;
        $display("checks %0d fails %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #5 i_clk = ~i_clk;
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_pulse();
        t_restart();
        t_ignore();
        summarize();
    end
    initial #20us begin
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
